// [design/sisr_pkg.sv]
// constants, field layouts and state types for the slot interrupt block
// assumes one core clock and a register port fed by the serial decoder
package sisr_pkg;

  localparam int NUM_SLOTS = 12;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [14:0] FIFO_STATUS_OFS = 15'h0000;
  localparam logic [14:0] SLOT_READY_STATUS_OFS = 15'h0001;
  localparam logic [14:0] CH1_CEILING_STATUS_OFS = 15'h0004;
  localparam logic [14:0] CH2_CEILING_STATUS_OFS = 15'h0005;
  localparam logic [14:0] AUTO_CLEAR_CONTROL_OFS = 15'h0007;
  localparam logic [14:0] OUTPUT_X_ENABLE_OFS = 15'h0014;
  localparam logic [14:0] OUTPUT_Y_ENABLE_OFS = 15'h0015;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int FIFO_LEVEL_BIT = 15;
  localparam int FIFO_UNDERRUN_BIT = 14;
  localparam int FIFO_OVERRUN_BIT = 13;
  localparam int SLOT_MSB = 11;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [11:0] SLOT_AUTOCLEAR_RST = 12'hfff;
  localparam logic FIFO_AUTOCLEAR_RST = 1'b1;
  localparam logic [11:0] SLOT_FLAG_RST = 12'h000;
  localparam logic [11:0] SLOT_EN_RST = 12'h000;
  localparam logic [2:0] FIFO_EN_RST = 3'h0;

  // one output's routing enables: level, underrun, overrun, slots
  typedef struct packed {
    logic fifo_level_en;
    logic fifo_underrun_en;
    logic fifo_overrun_en;
    logic [11:0] slot_ready_en;
  } sisr_out_en_s;

  // event strobes from the sample path and fifo
  typedef struct packed {
    logic [11:0] slot_update;
    logic [11:0] ch1_over;
    logic [11:0] ch2_over;
    logic [11:0] slot_read;
    logic fifo_level_event;
    logic fifo_underrun_event;
    logic fifo_overrun_event;
    logic fifo_read;
  } sisr_events_s;

  // whole block state
  typedef struct packed {
    logic [11:0] ch1_ceiling_flag;
    logic [11:0] ch2_ceiling_flag;
    logic [11:0] slot_ready_flag;
    logic fifo_level_irq_flag;
    logic fifo_underrun_flag;
    logic fifo_overrun_flag;
    logic fifo_level_autoclear_en;
    logic [11:0] slot_ready_autoclear_en;
    sisr_out_en_s outx;
    sisr_out_en_s outy;
    logic [15:0] rdata;
    logic irq_x;
    logic irq_y;
  } sisr_state_s;

endpackage : sisr_pkg

// [design/sisr_top.sv]
// slot interrupt status, auto-clear and x/y interrupt routing
// assumes the serial port decoder and sample path share core_clk
`timescale 1ns/1ps
module sisr_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // register port from the serial decoder
  input wire logic [14:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // events from sample path and fifo
  input wire sisr_pkg::sisr_events_s events,
  // interrupt outputs
  output logic irq_x,
  output logic irq_y
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state
  sisr_pkg::sisr_state_s state_reg;
  sisr_pkg::sisr_state_s state_next;
  sisr_pkg::sisr_state_s state_rst;

  always_comb begin
    state_rst = '0;
    state_rst.fifo_level_autoclear_en = sisr_pkg::FIFO_AUTOCLEAR_RST;
    state_rst.slot_ready_autoclear_en = sisr_pkg::SLOT_AUTOCLEAR_RST;
    state_rst.outx.slot_ready_en = sisr_pkg::SLOT_EN_RST;
    state_rst.outy.slot_ready_en = sisr_pkg::SLOT_EN_RST;
  end

  // write decode: one strobe per register
  logic wr_fifo;
  logic wr_ready;
  logic wr_ch1;
  logic wr_ch2;
  logic wr_aclr;
  logic wr_x;
  logic wr_y;

  always_comb begin
    wr_fifo = reg_wr && (reg_addr == sisr_pkg::FIFO_STATUS_OFS);
    wr_ready = reg_wr && (reg_addr == sisr_pkg::SLOT_READY_STATUS_OFS);
    wr_ch1 = reg_wr && (reg_addr == sisr_pkg::CH1_CEILING_STATUS_OFS);
    wr_ch2 = reg_wr && (reg_addr == sisr_pkg::CH2_CEILING_STATUS_OFS);
    wr_aclr = reg_wr && (reg_addr == sisr_pkg::AUTO_CLEAR_CONTROL_OFS);
    wr_x = reg_wr && (reg_addr == sisr_pkg::OUTPUT_X_ENABLE_OFS);
    wr_y = reg_wr && (reg_addr == sisr_pkg::OUTPUT_Y_ENABLE_OFS);
  end

  // next-state: a set in the same cycle as a clear always wins
  always_comb begin
    logic [11:0] ready_clr;
    logic [11:0] ready_set;
    logic lvl_clr;
    ready_clr = '0;
    ready_set = '0;
    lvl_clr = 1'b0;
    state_next = state_reg;

    // ceiling flags, slots in 11:0
    state_next.ch1_ceiling_flag = (state_reg.ch1_ceiling_flag
      & ~({12{wr_ch1}} & reg_wdata[11:0]))
      | (events.slot_update & events.ch1_over);
    state_next.ch2_ceiling_flag = (state_reg.ch2_ceiling_flag
      & ~({12{wr_ch2}} & reg_wdata[11:0]))
      | (events.slot_update & events.ch2_over);

    // slot ready: write-one or read with autoclear enabled
    ready_clr = ({12{wr_ready}} & reg_wdata[11:0])
      | (events.slot_read & state_reg.slot_ready_autoclear_en);
    ready_set = events.slot_update;
    // a read with autoclear off leaves the flag alone
    state_next.slot_ready_flag =
      (state_reg.slot_ready_flag & ~ready_clr) | ready_set;

    // fifo level flag also clears on a fifo read when enabled
    lvl_clr = (wr_ready && reg_wdata[sisr_pkg::FIFO_LEVEL_BIT])
      || (events.fifo_read && state_reg.fifo_level_autoclear_en);
    state_next.fifo_level_irq_flag = (state_reg.fifo_level_irq_flag
      && !lvl_clr) || events.fifo_level_event;
    state_next.fifo_underrun_flag = (state_reg.fifo_underrun_flag
      && !(wr_fifo && reg_wdata[sisr_pkg::FIFO_UNDERRUN_BIT]))
      || events.fifo_underrun_event;
    state_next.fifo_overrun_flag = (state_reg.fifo_overrun_flag
      && !(wr_fifo && reg_wdata[sisr_pkg::FIFO_OVERRUN_BIT]))
      || events.fifo_overrun_event;

    // plain read-write controls; reserved bits are dropped
    if (wr_aclr) begin
      state_next.fifo_level_autoclear_en =
        reg_wdata[sisr_pkg::FIFO_LEVEL_BIT];
      state_next.slot_ready_autoclear_en = reg_wdata[11:0];
    end
    if (wr_x) begin
      state_next.outx = {reg_wdata[15:13], reg_wdata[11:0]};
    end
    if (wr_y) begin
      state_next.outy = {reg_wdata[15:13], reg_wdata[11:0]};
    end

    // outputs track the flags that are stored this same edge
    state_next.irq_x =
      (state_next.outx.fifo_level_en && state_next.fifo_level_irq_flag)
      || (state_next.outx.fifo_underrun_en
          && state_next.fifo_underrun_flag)
      || (state_next.outx.fifo_overrun_en
          && state_next.fifo_overrun_flag)
      || |(state_next.outx.slot_ready_en
           & state_next.slot_ready_flag);
    state_next.irq_y =
      (state_next.outy.fifo_level_en && state_next.fifo_level_irq_flag)
      || (state_next.outy.fifo_underrun_en
          && state_next.fifo_underrun_flag)
      || (state_next.outy.fifo_overrun_en
          && state_next.fifo_overrun_flag)
      || |(state_next.outy.slot_ready_en
           & state_next.slot_ready_flag);

    // read data, registered; reserved and unmapped read as zero
    state_next.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        sisr_pkg::FIFO_STATUS_OFS: state_next.rdata =
          {1'b0, state_reg.fifo_underrun_flag,
           state_reg.fifo_overrun_flag, 13'h0000};
        sisr_pkg::SLOT_READY_STATUS_OFS: state_next.rdata =
          {state_reg.fifo_level_irq_flag, 3'h0,
           state_reg.slot_ready_flag};
        sisr_pkg::CH1_CEILING_STATUS_OFS: state_next.rdata =
          {4'h0, state_reg.ch1_ceiling_flag};
        sisr_pkg::CH2_CEILING_STATUS_OFS: state_next.rdata =
          {4'h0, state_reg.ch2_ceiling_flag};
        sisr_pkg::AUTO_CLEAR_CONTROL_OFS: state_next.rdata =
          {state_reg.fifo_level_autoclear_en, 3'h0,
           state_reg.slot_ready_autoclear_en};
        sisr_pkg::OUTPUT_X_ENABLE_OFS: state_next.rdata =
          {state_reg.outx.fifo_level_en, state_reg.outx.fifo_underrun_en,
           state_reg.outx.fifo_overrun_en, 1'b0,
           state_reg.outx.slot_ready_en};
        sisr_pkg::OUTPUT_Y_ENABLE_OFS: state_next.rdata =
          {state_reg.outy.fifo_level_en, state_reg.outy.fifo_underrun_en,
           state_reg.outy.fifo_overrun_en, 1'b0,
           state_reg.outy.slot_ready_en};
        default: state_next.rdata = 16'h0000;
      endcase
    end
  end

  // single state register on the synchronised reset
  always_ff @(posedge core_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg <= state_rst;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata = state_reg.rdata;
  assign irq_x = state_reg.irq_x;
  assign irq_y = state_reg.irq_y;

endmodule : sisr_top

// [testbench/sisr_host.sv]
// host model: reads and writes over the register port
// assumes it shares core_clk with the design
`timescale 1ns/1ps
module sisr_host (
  // clock
  input wire logic core_clk,
  // register port
  output logic [14:0] reg_addr,
  output logic reg_wr,
  output logic [15:0] reg_wdata,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata
);
  // idle port; stale data is inverted so a late sample shows
  initial begin
    reg_addr = 15'h0000;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [14:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    #1;
  endtask : wr
  task automatic rd(input logic [14:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
endmodule : sisr_host

// [testbench/sisr_sva.sv]
// checker for the slot interrupt block, bound onto sisr_top
// assumes one core clock; enables shadowed from port writes
`timescale 1ns/1ps
module sisr_sva (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // register port
  input wire logic [14:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // events and interrupt outputs
  input wire sisr_pkg::sisr_events_s events,
  input wire logic irq_x,
  input wire logic irq_y
);
  logic [15:0] enx_reg;
  logic [15:0] eny_reg;
  logic [2:0] fifo_ev;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  //////////////////////////////////////////////////////////////////////////
  // shadow enables; bit 12 is reserved so it never sticks
  assign fifo_ev = {events.fifo_level_event, events.fifo_underrun_event,
    events.fifo_overrun_event};
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      enx_reg <= 16'h0000;
      eny_reg <= 16'h0000;
    end else if (reg_wr && reg_addr == 15'h0014) begin
      enx_reg <= reg_wdata & 16'hefff;
    end else if (reg_wr && reg_addr == 15'h0015) begin
      eny_reg <= reg_wdata & 16'hefff;
    end
  end
  AST_X_SLOT: assert property (|(events.slot_update & enx_reg[11:0])
    |=> irq_x) else $error("x missed slot ready");
  AST_Y_SLOT: assert property (|(events.slot_update & eny_reg[11:0])
    |=> irq_y) else $error("y missed slot ready");
  AST_X_FIFO: assert property (|(fifo_ev & enx_reg[15:13])
    |=> irq_x) else $error("x missed fifo flag");
  AST_Y_FIFO: assert property (|(fifo_ev & eny_reg[15:13])
    |=> irq_y) else $error("y missed fifo flag");
  AST_X_MASKED: assert property (enx_reg == 16'h0000 |-> !irq_x)
    else $error("x driven while masked");
  AST_Y_MASKED: assert property (eny_reg == 16'h0000 |-> !irq_y)
    else $error("y driven while masked");
  AST_EN_READ: assert property (reg_rd && reg_addr == 15'h0014
    |=> reg_rdata == $past(enx_reg)) else $error("x enable readback");
  AST_RSVD_CEIL: assert property (reg_rd && reg_addr[14:1] == 14'h0002
    |=> reg_rdata[15:12] == 4'h0) else $error("ceiling reserved bits");
  AST_RSVD_ACLR: assert property (reg_rd && reg_addr == 15'h0007
    |=> reg_rdata[14:12] == 3'h0) else $error("autoclear reserved bits");
endmodule : sisr_sva

// [testbench/sisr_top_tb.sv]
// bench for the slot interrupt block: host model plus event pulses
// assumes package, design, host model and checker compiled first
`timescale 1ns/1ps
bind sisr_top sisr_sva chk_i (.core_clk, .reset_n, .reg_addr, .reg_wr,
  .reg_wdata, .reg_rd, .reg_rdata, .events, .irq_x, .irq_y);
module sisr_top_tb;
  logic core_clk, reset_n, reg_wr, reg_rd, irq_x, irq_y;
  logic [14:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, v;
  sisr_pkg::sisr_events_s ev, e;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  sisr_top dut (.core_clk, .reset_n, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rd, .reg_rdata, .events(ev), .irq_x, .irq_y);
  sisr_host host (.core_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata);
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      $display("wrong value %0t got %h want %h", $time, got, exp);
      bad_count++;
    end
  endtask : chk
  task automatic rdchk(input logic [14:0] a, input logic [15:0] exp);
    host.rd(a, v);
    chk(v, exp);
  endtask : rdchk
  // one-cycle event pulse; outputs settle just after the sampling edge
  task automatic pulse(input sisr_pkg::sisr_events_s p);
    @(posedge core_clk) ev <= p;
    @(posedge core_clk) ev <= '0;
    #1;
  endtask : pulse
  task automatic t_ceil;
    e = '0;
    e.slot_update = 12'hfff;
    e.ch1_over = 12'h201;
    e.ch2_over = 12'h801;
    pulse(e);
    chk({14'h0, irq_x, irq_y}, 16'h0000);
    rdchk(15'h0007, 16'h8fff);
    rdchk(15'h0004, 16'h0201);
    rdchk(15'h0005, 16'h0801);
    host.wr(15'h0005, 16'h0000);
    rdchk(15'h0005, 16'h0801);
    host.wr(15'h0005, 16'hf001);
    rdchk(15'h0005, 16'h0800);
    rdchk(15'h0001, 16'h0fff);
    $display("ceiling test done");
  endtask : t_ceil
  task automatic t_ready;
    host.wr(15'h0001, 16'h0fff);
    host.wr(15'h0014, 16'hffff);
    rdchk(15'h0014, 16'hefff);
    host.wr(15'h0015, 16'h0800);
    host.wr(15'h0007, 16'h0000);
    e = '0;
    e.slot_update[11] = 1'b1;
    pulse(e);
    chk({14'h0, irq_x, irq_y}, 16'h0003);
    e = '0;
    e.slot_read[11] = 1'b1;
    pulse(e);
    chk({14'h0, irq_x, irq_y}, 16'h0003);
    host.wr(15'h0007, 16'h0800);
    pulse(e);
    chk({14'h0, irq_x, irq_y}, 16'h0000);
    $display("ready test done");
  endtask : t_ready
  // each fifo flag alone on both outputs, then cleared by write-one
  task automatic t_fifo;
    for (int i = 0; i < 3; i++) begin
      host.wr(15'h0014, 16'h8000 >> i);
      host.wr(15'h0015, 16'h8000 >> i);
      e = '0;
      e[3:1] = 3'b100 >> i;
      pulse(e);
      chk({14'h0, irq_x, irq_y}, 16'h0003);
      host.wr((i == 0) ? 15'h0001 : 15'h0000, 16'h8000 >> i);
      chk({14'h0, irq_x, irq_y}, 16'h0000);
    end
    host.wr(15'h0007, 16'h8000);
    host.wr(15'h0015, 16'h8000);
    e = '0;
    e.fifo_level_event = 1'b1;
    pulse(e);
    chk({14'h0, irq_x, irq_y}, 16'h0001);
    e = '0;
    e.fifo_read = 1'b1;
    pulse(e);
    chk({14'h0, irq_x, irq_y}, 16'h0000);
    $display("fifo test done");
  endtask : t_fifo
  task automatic end_of_test;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test
  //////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // hang guard, far above the fewer than a hundred cycles the tests need
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      end_of_test;
    end
  end
  initial begin
    reset_n = 1'b0;
    ev = '0;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_ceil;
    t_ready;
    t_fifo;
    end_of_test;
  end
endmodule : sisr_top_tb
